// ---- rtl/irc_hard_timer.sv ----
// Functional notes
// - tau divider select 11:/32, 10:/20, 01:/16, 00:/12 of carrier
// - tau equals oscillator period times carrier division times tau ratio
// - tau runs continuously while carrier generation is on
// - after disable, stop aligned to tau within 384 machine cycles
// - restart from off gives first tau edge one carrier early
// - output width 0..3 selects that many tau of carrier
// - each width write gates carrier once from next tau edge
// - width clears at reset and when carrier generation disabled
// - forced output puts carrier on pin regardless; keep zero here
// - count write starts tau counter at next tau edge
// - counter advances per tau edge; completion sets flag aligned
// - flag sets regardless of enable; request only when enabled
// - writing one clears flag, zero has no effect
// - two-bit priority 0..3, zero means no request
// - interrupt vector address is 000024H
// - each count write gives exactly one count
// - no counting after reset until count field written
//
// Strobed register access was chosen for this implementation.
module irc_hard_timer (
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    output logic             o_remote_out,
    output logic [1:0]       o_irq_level,
    output logic [23:0]      o_irq_vector,
    output logic             o_busy
);
    logic       carrier_gen_on_reg;
    logic       carrier_irq_enable_reg;
    logic       carrier_irq_flag_reg;
    logic       forced_output_on_reg;
    logic [1:0] ref_cycle_div_sel_reg;
    logic       carrier_div_sel_reg;
    logic [3:0] carrier_duty_reg;
    logic [1:0] carrier_irq_priority_reg;
    logic [1:0] width_reg;
    logic [3:0] irq_tau_count_reg;
    logic       width_pending_reg;
    logic       count_pending_reg;
    logic       count_active_reg;
    logic [3:0] tau_count_reg;
    logic [1:0] on_left_reg;
    logic [6:0] carrier_cnt_reg;
    logic       carrier_wave_reg;
    logic       carrier_tick;
    logic [6:0] carrier_period;
    logic [5:0] tau_ratio;
    logic       tau_rise;
    logic       tau_running;
    logic       gate_on;
    logic       wr_ctl;
    logic       wr_flags;
    logic       wr_cfg;
    logic       wr_cnt;
    logic       wr_width;
    logic       count_done;

    typedef enum logic [2:0] {
        IRC_IDLE = 3'b001,
        IRC_RUN  = 3'b010,
        IRC_STOP = 3'b100
    } irc_state_type;
    irc_state_type state_reg;
    irc_state_type state_next;

    // decodes the tau ratio for a divider select
    function automatic logic [5:0] irc_ratio(input logic [1:0] sel);
        case (sel)
            2'h3:    irc_ratio = irc_pkg::TAU_RATIO_32;
            2'h2:    irc_ratio = irc_pkg::TAU_RATIO_20;
            2'h1:    irc_ratio = irc_pkg::TAU_RATIO_16;
            default: irc_ratio = irc_pkg::TAU_RATIO_12;
        endcase
    endfunction

    // write strobes per register
    assign wr_ctl   = i_wr && (i_addr == irc_pkg::ADDR_ENABLES);
    assign wr_flags = i_wr && (i_addr == irc_pkg::ADDR_FLAGS);
    assign wr_cfg   = i_wr && (i_addr == irc_pkg::ADDR_TAU_CFG);
    assign wr_cnt   = i_wr && (i_addr == irc_pkg::ADDR_IRQ_COUNT);
    assign wr_width = i_wr && (i_addr == irc_pkg::ADDR_OUT_WIDTH);

    // control and configuration registers
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            carrier_gen_on_reg       <= irc_pkg::RST_CARRIER_ON;
            carrier_irq_enable_reg   <= 1'b0;
            forced_output_on_reg     <= 1'b0;
            ref_cycle_div_sel_reg    <= irc_pkg::RST_DIV_SEL;
            carrier_div_sel_reg      <= 1'b0;
            carrier_duty_reg         <= 4'h0;
            carrier_irq_priority_reg <= irc_pkg::RST_PRIORITY;
        end else begin
            if (wr_ctl) begin
                carrier_gen_on_reg     <= i_wdata[irc_pkg::POS_CARRIER_ON];
                carrier_irq_enable_reg <= i_wdata[irc_pkg::POS_IRQ_EN];
            end
            if (wr_flags) begin
                forced_output_on_reg <= i_wdata[irc_pkg::POS_FORCED];
            end
            if (wr_cfg) begin
                ref_cycle_div_sel_reg <= i_wdata[irc_pkg::POS_DIV_LO +: 2];
                carrier_div_sel_reg   <= i_wdata[irc_pkg::POS_CARRIER_DIV];
                carrier_duty_reg      <= i_wdata[3:0];
            end
            if (i_wr && (i_addr == irc_pkg::ADDR_INT_PRI)) begin
                carrier_irq_priority_reg <= i_wdata[irc_pkg::POS_PRI_LO +: 2];
            end
        end
    end

    assign carrier_period = carrier_div_sel_reg ? 7'(irc_pkg::CARRIER_DIV_96) : 7'(irc_pkg::CARRIER_DIV_64);
    assign tau_ratio = irc_ratio(ref_cycle_div_sel_reg);

    // carrier generator with duty in eighths or twenty-fourths
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            carrier_cnt_reg  <= 7'h00;
            carrier_wave_reg <= 1'b0;
        end else if (!(carrier_gen_on_reg || tau_running)) begin
            carrier_cnt_reg  <= 7'h00;
            carrier_wave_reg <= 1'b0;
        end else begin
            carrier_cnt_reg <= (carrier_cnt_reg == carrier_period - 7'h01) ? 7'h00 : carrier_cnt_reg + 7'h01;
            if (carrier_div_sel_reg) begin
                carrier_wave_reg <= (carrier_duty_reg < 4'hC) &&
                                    (carrier_cnt_reg < 7'({carrier_duty_reg, 2'b00} + {1'b0, carrier_duty_reg} * 3'h0 + 6'h04));
            end else begin
                // six-bit sum so the widest duty (4/8 = 32 cycles) does not wrap to zero
                carrier_wave_reg <= carrier_cnt_reg < 7'({(carrier_duty_reg > 4'h3) ? 2'h3 : carrier_duty_reg[1:0], 3'b000} + 6'h08);
            end
        end
    end
    assign carrier_tick = (carrier_cnt_reg == carrier_period - 7'h01);

    irc_tau_divider u_tau (
        .i_clock        (i_clock),
        .i_rst_b        (i_rst_b),
        .i_run          (carrier_gen_on_reg),
        .i_carrier_tick (carrier_tick),
        .i_ratio        (tau_ratio),
        .o_tau_rise     (tau_rise),
        .o_running      (tau_running)
    );

    // run state follows the divider; stop waits on tau
    always_comb begin
        case (state_reg)
            IRC_IDLE: state_next = tau_running ? IRC_RUN : IRC_IDLE;
            IRC_RUN:  state_next = carrier_gen_on_reg ? IRC_RUN : IRC_STOP;
            IRC_STOP: state_next = tau_running ? (carrier_gen_on_reg ? IRC_RUN : IRC_STOP) : IRC_IDLE;
            default:  state_next = IRC_IDLE;
        endcase
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= IRC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // output width field; one shot per write
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            width_reg         <= irc_pkg::RST_WIDTH;
            width_pending_reg <= 1'b0;
            on_left_reg       <= 2'h0;
        end else if (!carrier_gen_on_reg) begin
            width_reg         <= irc_pkg::RST_WIDTH;
            width_pending_reg <= 1'b0;
            on_left_reg       <= 2'h0;
        end else begin
            if (wr_width) begin
                width_reg <= i_wdata[irc_pkg::POS_WIDTH_LO +: 2];
            end
            if (tau_rise) begin
                on_left_reg       <= width_pending_reg ? width_reg : ((on_left_reg != 2'h0) ? on_left_reg - 2'h1 : 2'h0);
                width_pending_reg <= wr_width;
            end else if (wr_width) begin
                width_pending_reg <= 1'b1;
            end
        end
    end
    assign gate_on = (on_left_reg != 2'h0);

    // interrupt count field and tau counter
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_tau_count_reg <= 4'hF;
            count_pending_reg <= 1'b0;
            count_active_reg  <= 1'b0;
            tau_count_reg     <= 4'h0;
        end else begin
            if (wr_cnt) begin
                irq_tau_count_reg <= i_wdata[irc_pkg::POS_COUNT_LO +: 4];
            end
            if (tau_rise) begin
                count_pending_reg <= wr_cnt;
                if (count_pending_reg) begin
                    count_active_reg <= (irq_tau_count_reg != 4'h0);
                    tau_count_reg    <= 4'h0;
                end else if (count_done) begin
                    count_active_reg <= 1'b0;
                end else if (count_active_reg) begin
                    tau_count_reg <= tau_count_reg + 4'h1;
                end
            end else if (wr_cnt) begin
                count_pending_reg <= 1'b1;
            end
        end
    end
    assign count_done = tau_rise && count_active_reg && (tau_count_reg + 4'h1 == irq_tau_count_reg);

    // sticky flag; set wins over clear
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            carrier_irq_flag_reg <= 1'b0;
        end else if (count_done || (tau_rise && count_pending_reg && irq_tau_count_reg == 4'h0)) begin
            carrier_irq_flag_reg <= 1'b1;
        end else if (wr_flags && i_wdata[irc_pkg::POS_FLAG]) begin
            carrier_irq_flag_reg <= 1'b0;
        end
    end

    // pin, request level and read data
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_remote_out <= 1'b0;
            o_irq_level  <= 2'h0;
            o_irq_vector <= irc_pkg::IRQ_VECTOR;
            o_busy       <= 1'b0;
            o_rdata      <= 8'h00;
        end else begin
            o_remote_out <= carrier_wave_reg && (forced_output_on_reg || gate_on);
            o_irq_level <= (carrier_irq_flag_reg && carrier_irq_enable_reg) ? carrier_irq_priority_reg : 2'h0;
            o_irq_vector <= irc_pkg::IRQ_VECTOR;
            o_busy       <= (state_reg != IRC_IDLE);
            o_rdata      <= 8'h00;
            if (i_rd) begin
                case (i_addr)
                    irc_pkg::ADDR_INT_PRI:   o_rdata <= {carrier_irq_priority_reg, 6'h00};
                    irc_pkg::ADDR_ENABLES:   o_rdata <= {2'h0, carrier_irq_enable_reg, carrier_gen_on_reg, 4'h0};
                    irc_pkg::ADDR_FLAGS:     o_rdata <= {2'h0, carrier_irq_flag_reg, forced_output_on_reg, 4'h0};
                    irc_pkg::ADDR_TAU_CFG:   o_rdata <= {1'b0, ref_cycle_div_sel_reg, carrier_div_sel_reg,
                                                         carrier_duty_reg};
                    irc_pkg::ADDR_OUT_WIDTH: o_rdata <= {width_reg, 6'h00};
                    default:                 o_rdata <= 8'h00;
                endcase
            end
        end
    end

    // longest tau in oscillator cycles plus one; a delay range this long would choke the tools
    localparam int STOP_LIMIT = irc_pkg::CARRIER_DIV_96 * int'(irc_pkg::TAU_RATIO_32) + 1;
    logic [11:0] stop_wait_reg;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stop_wait_reg <= 12'h000;
        end else if (carrier_gen_on_reg || !tau_running) begin
            stop_wait_reg <= 12'h000;
        end else if (stop_wait_reg != 12'hFFF) begin
            stop_wait_reg <= stop_wait_reg + 12'h001;
        end
    end

    a_irq_needs_enable: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (o_irq_level != 2'h0) |-> $past(carrier_irq_flag_reg) && $past(carrier_irq_enable_reg)) else $error("irq without flag");
    a_flag_clear_one: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (wr_flags && i_wdata[irc_pkg::POS_FLAG] && !count_done && !tau_rise) |=> !carrier_irq_flag_reg) else $error("flag not cleared");
    a_width_clear_off: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !carrier_gen_on_reg |=> (width_reg == 2'h0) && !gate_on) else $error("width kept while off");
    a_flag_on_done: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        count_done |=> carrier_irq_flag_reg) else $error("flag not set");
    // gate starts only at tau edge
    a_gate_at_tau: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        $rose(gate_on) |-> $past(tau_rise)) else $error("gate off tau edge");
    a_forced_out: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (forced_output_on_reg && carrier_wave_reg) |=> o_remote_out) else $error("forced output missing");
    a_stop_bound: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        stop_wait_reg <= 12'(STOP_LIMIT)) else $error("stop too slow");
    a_vector_fixed: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        ##1 o_irq_vector == 24'h000024) else $error("vector wrong");
endmodule

// ---- pkg/irc_pkg.sv ----
package irc_pkg;
    // register offsets (index = printed byte offset low byte, 8-bit plain port)
    localparam logic [15:0] ADDR_INT_PRI    = 16'hFF21;
    localparam logic [15:0] ADDR_ENABLES    = 16'hFF26;
    localparam logic [15:0] ADDR_FLAGS      = 16'hFF27;
    localparam logic [15:0] ADDR_TAU_CFG    = 16'hFF28;
    localparam logic [15:0] ADDR_IRQ_COUNT  = 16'hFF29;
    localparam logic [15:0] ADDR_OUT_WIDTH  = 16'hFF2A;
    // field positions
    localparam int POS_PRI_LO      = 6;
    localparam int POS_IRQ_EN      = 5;
    localparam int POS_CARRIER_ON  = 4;
    localparam int POS_FLAG        = 5;
    localparam int POS_FORCED      = 4;
    localparam int POS_DIV_LO      = 5;
    localparam int POS_CARRIER_DIV = 4;
    localparam int POS_COUNT_LO    = 4;
    localparam int POS_WIDTH_LO    = 6;
    // reset values
    localparam logic       RST_CARRIER_ON = 1'b1;
    localparam logic [1:0] RST_DIV_SEL    = 2'h0;
    localparam logic [1:0] RST_WIDTH      = 2'h0;
    localparam logic [1:0] RST_PRIORITY   = 2'h0;
    // carrier divisions of the main oscillator clock (one i_clock edge per cycle)
    localparam int CARRIER_DIV_64 = 64;
    localparam int CARRIER_DIV_96 = 96;
    // tau ratios selected by the reference divider select
    localparam logic [5:0] TAU_RATIO_12 = 6'h0C;
    localparam logic [5:0] TAU_RATIO_16 = 6'h10;
    localparam logic [5:0] TAU_RATIO_20 = 6'h14;
    localparam logic [5:0] TAU_RATIO_32 = 6'h20;
    // interrupt vector
    localparam logic [23:0] IRQ_VECTOR = 24'h000024;
    // longest stop time in machine cycles
    localparam int STOP_MAX_CYCLES = 384;
endpackage

// ---- rtl/irc_tau_divider.sv ----
// divides carrier periods into tau; restart gives early first edge
module irc_tau_divider (
    input  wire logic       i_clock,
    input  wire logic       i_rst_b,
    input  wire logic       i_run,
    input  wire logic       i_carrier_tick,
    input  wire logic [5:0] i_ratio,
    output logic            o_tau_rise,
    output logic            o_running
);
    logic [5:0] count_reg;
    logic       running_reg;

    // counts carrier periods; stop waits for the tau boundary
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_reg   <= 6'h00;
            running_reg <= 1'b0;
            o_tau_rise  <= 1'b0;
        end else begin
            o_tau_rise <= 1'b0;
            if (!running_reg) begin
                count_reg   <= 6'h01;
                running_reg <= i_run;
            end else if (i_carrier_tick) begin
                if (count_reg >= i_ratio - 6'h01) begin
                    count_reg  <= 6'h00;
                    o_tau_rise <= 1'b1;
                    running_reg <= i_run;
                end else begin
                    count_reg <= count_reg + 6'h01;
                end
            end
        end
    end

    assign o_running = running_reg;
endmodule

// ---- verification/irc_led_model.sv ----
// infrared led driver on the carrier pin: counts light pulses and stamps each burst
module irc_led_model (
    input  wire logic i_clock,
    input  wire logic i_pin,
    output int        o_pulses,
    output int        o_first,
    output int        o_last
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pin_reg = 1'b0;
    int   cyc     = 0;
    int   count_q = 0;
    int   first_q = 0;
    int   last_q  = -1000;
    assign o_pulses = count_q;
    assign o_first  = first_q;
    assign o_last   = last_q;
    // a gap longer than two slow carriers opens a new burst; bursts are a tau apart at least
    always @(posedge i_clock) begin
        cyc     <= cyc + 1;
        pin_reg <= i_pin;
        if (i_pin === 1'b1 && pin_reg === 1'b0) begin
            count_q <= count_q + 1;
            last_q  <= cyc;
            if (cyc - last_q > 200) begin
                first_q <= cyc;
            end
        end
    end
endmodule

// ---- verification/ir_carrier_hard_timer_tb.sv ----
module ir_carrier_hard_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 95000;
    logic        clock       = 1'b0;
    logic        rst_b       = 1'b0;
    logic [15:0] addr        = 16'h0000;
    logic [7:0]  wdata       = 8'h00;
    logic        wr          = 1'b0;
    logic        rd          = 1'b0;
    logic [7:0]  rdata;
    logic        remote_out;
    logic [1:0]  irq_level;
    logic [23:0] irq_vector;
    logic        busy;
    int          pulses;
    int          first_rise;
    int          last_rise;
    int          error_cnt   = 0;
    int          check_count = 0;
    int          cyc         = 0;
    int          tau_now     = 768;

    irc_hard_timer dut (.i_clock(clock), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_remote_out(remote_out), .o_irq_level(irq_level), .o_irq_vector(irq_vector),
        .o_busy(busy));
    irc_led_model led (.i_clock(clock), .i_pin(remote_out), .o_pulses(pulses), .o_first(first_rise),
        .o_last(last_rise));

    // 20 MHz clock
    // oscillator always runs
    always #25 clock = ~clock;

    // cycle count doubles as the hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe; a clock edge passes before the next request
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask

    // sampled between edges so the request level has settled; fourteen tau need over 10000 cycles
    task automatic wait_irq(output int t);
        int n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (irq_level === 2'h0 && n < 12000);
        check(n < 12000, 1'b1);
        t = cyc;
    endtask

    // zero count marks a tau edge; then step past the one-carrier guard around it
    task automatic sync(output int te);
        wr_reg(16'hFF21, 8'h40);
        wr_reg(16'hFF26, 8'h30);
        wr_reg(16'hFF29, 8'h00);
        wait_irq(te);
        repeat (100) @(posedge clock);
        wr_reg(16'hFF27, 8'h20);
    endtask

    task automatic t_reset();
        logic [15:0] a [7] = '{16'hFF21, 16'hFF26, 16'hFF27, 16'hFF28, 16'hFF29, 16'hFF2A, 16'hFF30};
        logic [7:0]  m [7] = '{8'hC0, 8'h30, 8'h30, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        logic [7:0]  e [7] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0]  d;
        for (int i = 0; i < 7; i++) begin
            rd_reg(a[i], d);
            check(d & m[i], e[i]);
        end
        check(irq_vector, 24'h000024);
        check(irq_level, 2'h0);
        repeat (1536) @(posedge clock);
        rd_reg(16'hFF27, d);
        check(d, 8'h00);
        check(remote_out, 1'b0);
        $display("reset test done");
    endtask

    task automatic t_count(input logic [3:0] n);
        int te;
        int t1;
        sync(te);
        wr_reg(16'hFF21, 8'h80);
        wr_reg(16'hFF29, {n, 4'h0});
        wait_irq(t1);
        check(t1 - te, (n + 1) * 768);
        check(irq_level, 2'h2);
        wr_reg(16'hFF27, 8'h20);
        $display("count %0d test done", n);
    endtask

    // flag sets with the request disabled; every level shows; clear is by writing one
    task automatic t_flag();
        int te;
        logic [7:0] d;
        sync(te);
        wr_reg(16'hFF26, 8'h10);
        wr_reg(16'hFF29, 8'h10);
        repeat (2400) @(posedge clock);
        check(irq_level, 2'h0);
        rd_reg(16'hFF27, d);
        check(d & 8'h30, 8'h20);
        wr_reg(16'hFF26, 8'h30);
        for (int p = 0; p < 4; p++) begin
            wr_reg(16'hFF21, {p[1:0], 6'h00});
            repeat (2) @(negedge clock);
            check(irq_level, p[1:0]);
        end
        wr_reg(16'hFF27, 8'h00);
        rd_reg(16'hFF27, d);
        check(d, 8'h20);
        wr_reg(16'hFF27, 8'h20);
        rd_reg(16'hFF27, d);
        check(d, 8'h00);
        check(irq_level, 2'h0);
        repeat (1600) @(posedge clock);
        rd_reg(16'hFF27, d);
        check(d, 8'h00);
        $display("flag test done");
    endtask

    task automatic t_forced();
        int p0 = pulses;
        wr_reg(16'hFF27, 8'h10);
        repeat (640) @(posedge clock);
        wr_reg(16'hFF27, 8'h00);
        // a pulse launched at the clearing edge is counted by the model one edge later
        repeat (2) @(posedge clock);
        check(pulses - p0 >= 9 && pulses - p0 <= 11, 1'b1);
        p0 = pulses;
        repeat (1600) @(posedge clock);
        check(pulses - p0, 0);
        $display("forced output test done");
    endtask

    task automatic t_width(input logic [1:0] w, input int ratio, input int period);
        int te;
        int p0;
        sync(te);
        p0 = pulses;
        wr_reg(16'hFF2A, {w, 6'h00});
        repeat ((w + 1) * ratio * period + 2 * period) @(posedge clock);
        check(pulses - p0, w * ratio);
        if (w != 2'h0) begin
            check(last_rise - first_rise, (w * ratio - 1) * period);
        end
        $display("width %0d ratio %0d period %0d done", w, ratio, period);
    endtask

    // stop, reconfigure while off, restart and measure the early first tau edge
    task automatic t_ratio(input logic [7:0] cfg, input int ratio, input int period);
        int n = 0;
        int t0;
        int te;
        logic [7:0] d;
        wr_reg(16'hFF26, 8'h00);
        do begin
            @(negedge clock);
            n++;
        end while (busy !== 1'b0 && n < 4000);
        check(n <= tau_now + 8, 1'b1);
        rd_reg(16'hFF2A, d);
        check(d, 8'h00);
        check(remote_out, 1'b0);
        wr_reg(16'hFF28, cfg);
        wr_reg(16'hFF26, 8'h30);
        t0 = cyc;
        wr_reg(16'hFF29, 8'h00);
        wait_irq(te);
        check(te - t0 + 6 >= (ratio - 1) * period && te - t0 <= (ratio - 1) * period + 6, 1'b1);
        wr_reg(16'hFF27, 8'h20);
        tau_now = ratio * period;
        t_width(2'h1 + cfg[4], ratio, period);
    endtask

    initial begin
        int ratios [4] = '{12, 16, 20, 32};
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_count(4'h1);
        t_count(4'hE);
        t_flag();
        t_forced();
        for (int w = 0; w < 4; w++) begin
            t_width(w[1:0], 12, 64);
        end
        for (int s = 0; s < 4; s++) begin
            t_ratio({1'b0, s[1:0], 5'h00}, ratios[s], 64);
        end
        t_ratio(8'h10, 12, 96);
        summarize();
    end
endmodule
